// File: include/fnc_consts.vh
// Purpose: constants for the parallel NOR flash command controller
// Assumes: 250 MHz hclk, x16 flash with 20 address bits
// Notes:   one register word per 32-bit aligned offset
`ifndef FNC_CONSTS_VH
`define FNC_CONSTS_VH

// ==========================================================
// Register offsets
`define FNC_REG_CMD    8'h00
`define FNC_REG_ADDR   8'h04
`define FNC_REG_WDATA  8'h08
`define FNC_REG_RDATA  8'h0c
`define FNC_REG_STATUS 8'h10
`define FNC_REG_CFG    8'h14

// ==========================================================
// Status and config bit positions, reset values
`define FNC_ST_BUSY    0
`define FNC_ST_DONE    1
`define FNC_ST_ERR     2
`define FNC_ST_REFUSED 3
`define FNC_ST_ERASE   4
`define FNC_ST_SUSP    5
`define FNC_ST_RDY     6
`define FNC_CFG_WP     0
`define FNC_CFG_RESET  1'b1

// ==========================================================
// Operation codes written to the command register
`define FNC_OP_READ   3'h1
`define FNC_OP_PROG   3'h2
`define FNC_OP_SECT   3'h3
`define FNC_OP_BLOCK  3'h4
`define FNC_OP_SUSP   3'h5
`define FNC_OP_RESUME 3'h6
`define FNC_OP_POLL   3'h7

// ==========================================================
// Flash command words and unlock addresses
`define FNC_UNL_ADDR1  20'h00555
`define FNC_UNL_ADDR2  20'h002aa
`define FNC_UNL_DATA1  16'h00aa
`define FNC_UNL_DATA2  16'h0055
`define FNC_CMD_PROG   16'h00a0
`define FNC_CMD_ERASE  16'h0080
`define FNC_CMD_SECT   16'h0050
`define FNC_CMD_BLOCK  16'h0030
`define FNC_CMD_SUSP   16'h00b0
`define FNC_CMD_RESUME 16'h0030
`define FNC_TOGGLE_BIT 6
`define FNC_SECT_LSB   11
`define FNC_BLOCK_LSB  15

// ==========================================================
// Timing, in their own units, and derived cycle counts
`define FNC_CLK_MHZ     250
`define FNC_PERIOD_NS   4
`define FNC_T_ACC_NS    70
`define FNC_T_WE_NS     40
`define FNC_T_PROG_US   10
`define FNC_T_SUSP_US   20
`define FNC_ACC_CYC \
	((`FNC_T_ACC_NS + `FNC_PERIOD_NS - 1) / `FNC_PERIOD_NS)
`define FNC_WE_CYC \
	((`FNC_T_WE_NS + `FNC_PERIOD_NS - 1) / `FNC_PERIOD_NS)
`define FNC_PROG_CYC    (`FNC_T_PROG_US * `FNC_CLK_MHZ)
`define FNC_SUSP_CYC    (`FNC_T_SUSP_US * `FNC_CLK_MHZ)

`endif

// File: logic/fnc_bus_cycle.v
// Purpose: one asynchronous read or write cycle on the flash pins
// Assumes: flash inputs synchronous to hclk
// Notes:   done pulses one cycle after select is released
`timescale 1ns/100ps
`include "fnc_consts.vh"

module fnc_bus_cycle
#(
	parameter [7:0] ACC_CYC = `FNC_ACC_CYC,
	parameter [7:0] WE_CYC  = `FNC_WE_CYC
)
(
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// Request
	input  wire        start,
	input  wire        wr,
	input  wire [19:0] addr,
	input  wire [15:0] wdata,
	output reg         done,
	output reg  [15:0] rdata,
	// Flash pins
	output reg  [19:0] flash_addr,
	output reg         flash_ce_n,
	output reg         flash_we_n,
	output reg         flash_oe_n,
	output reg  [15:0] flash_dq_out,
	output reg         flash_dq_oe,
	input  wire [15:0] flash_dq_in
);

	localparam [2:0] C_IDLE  = 3'h0;
	localparam [2:0] C_SETUP = 3'h1;
	localparam [2:0] C_PULSE = 3'h2;
	localparam [2:0] C_HOLD  = 3'h3;
	localparam [2:0] C_GAP   = 3'h4;

	reg [2:0] state_reg;
	reg       wr_reg;
	reg [7:0] cnt_reg;

	// ==========================================================
	// Cycle sequencer
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg    <= C_IDLE;
			wr_reg       <= 1'b0;
			cnt_reg      <= 8'h00;
			done         <= 1'b0;
			rdata        <= 16'h0000;
			flash_addr   <= 20'h00000;
			flash_ce_n   <= 1'b1;
			flash_we_n   <= 1'b1;
			flash_oe_n   <= 1'b1;
			flash_dq_out <= 16'h0000;
			flash_dq_oe  <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			case (state_reg)
			C_IDLE:
				if (start)
				begin
					flash_addr   <= addr;
					flash_dq_out <= wdata;
					// never drive data while output enabled
					flash_dq_oe  <= wr;
					wr_reg       <= wr;
					flash_ce_n   <= 1'b0;
					state_reg    <= C_SETUP;
				end
			C_SETUP:
			begin
				// strobe falls only with select low
				if (wr_reg)
				begin
					flash_we_n <= 1'b0;
					cnt_reg    <= WE_CYC;
				end
				else
				begin
					flash_oe_n <= 1'b0;
					cnt_reg    <= ACC_CYC;
				end
				state_reg <= C_PULSE;
			end
			C_PULSE:
				if (cnt_reg <= 8'h01)
				begin
					// data held past the strobe rising edge
					flash_we_n <= 1'b1;
					flash_oe_n <= 1'b1;
					if (!wr_reg)
						rdata <= flash_dq_in;
					state_reg <= C_HOLD;
				end
				else
					cnt_reg <= cnt_reg - 8'h01;
			C_HOLD:
			begin
				flash_ce_n  <= 1'b1;
				state_reg   <= C_GAP;
			end
			C_GAP:
			begin
				flash_dq_oe <= 1'b0;
				done        <= 1'b1;
				state_reg   <= C_IDLE;
			end
			default:
				state_reg <= C_IDLE;
			endcase
		end
	end

endmodule

// File: logic/fnc_flash_ctrl.v
// Purpose: AHB-Lite controlled command engine for a parallel NOR flash
// Assumes: single-word AHB transfers, zero wait states
// Notes:   erase runs in the background; software polls with POLL
`timescale 1ns/100ps
`include "fnc_consts.vh"

module fnc_flash_ctrl
#(
	parameter [12:0] PROG_CYC = `FNC_PROG_CYC,
	parameter [12:0] SUSP_CYC = `FNC_SUSP_CYC
)
(
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// Flash pins
	output wire [19:0] flash_addr,
	output wire        flash_ce_n,
	output wire        flash_we_n,
	output wire        flash_oe_n,
	output wire [15:0] flash_dq_out,
	output wire        flash_dq_oe,
	input  wire [15:0] flash_dq_in,
	output wire        flash_wp_n,
	input  wire        flash_ready_busy_n
);

	localparam [1:0] S_IDLE  = 2'h0;
	localparam [1:0] S_ISSUE = 2'h1;
	localparam [1:0] S_WAIT  = 2'h2;
	localparam [1:0] S_SUSP  = 2'h3;

	// ==========================================================
	// Command sequences as address and data per step
	function [35:0] step_word;
		input [2:0]  op;
		input [2:0]  step;
		input [19:0] a;
		input [15:0] d;
		reg   [35:0] u1;
		reg   [35:0] u2;
		begin
			u1 = {`FNC_UNL_ADDR1, `FNC_UNL_DATA1};
			u2 = {`FNC_UNL_ADDR2, `FNC_UNL_DATA2};
			case (op)
			// two unlock writes and the program command, then address and data
			`FNC_OP_PROG:
				case (step)
				3'h0:    step_word = u1;
				3'h1:    step_word = u2;
				3'h2:    step_word = {`FNC_UNL_ADDR1, `FNC_CMD_PROG};
				default: step_word = {a, d};
				endcase
			`FNC_OP_SECT, `FNC_OP_BLOCK:
				case (step)
				3'h0:    step_word = u1;
				3'h1:    step_word = u2;
				3'h2:    step_word = {`FNC_UNL_ADDR1, `FNC_CMD_ERASE};
				3'h3:    step_word = u1;
				3'h4:    step_word = u2;
				default: step_word = (op == `FNC_OP_SECT) ?
					{a, `FNC_CMD_SECT} : {a, `FNC_CMD_BLOCK};
				endcase
			`FNC_OP_SUSP:   step_word = {a, `FNC_CMD_SUSP};
			`FNC_OP_RESUME: step_word = {a, `FNC_CMD_RESUME};
			default:        step_word = {a, d};
			endcase
		end
	endfunction

	function [2:0] last_step;
		input [2:0] op;
		begin
			case (op)
			`FNC_OP_PROG:  last_step = 3'h3;
			`FNC_OP_SECT:  last_step = 3'h5;
			`FNC_OP_BLOCK: last_step = 3'h5;
			default:       last_step = 3'h0;
			endcase
		end
	endfunction

	// ==========================================================
	// State
	reg  [1:0]  state_reg;
	reg  [2:0]  op_reg;
	reg  [2:0]  step_reg;
	reg  [19:0] addr_reg;
	reg  [15:0] wdata_reg;
	reg  [15:0] rdata_reg;
	reg  [15:0] prev_reg;
	reg  [12:0] tmo_reg;
	reg         polling_reg;
	reg         first_reg;
	reg         done_reg;
	reg         err_reg;
	reg         refused_reg;
	reg         erase_act_reg;
	reg         susp_reg;
	reg         er_blk_reg;
	reg  [19:0] er_addr_reg;
	reg         wp_cfg_reg;
	reg         cyc_start_reg;
	reg         ap_wr_reg;
	reg  [7:0]  ap_addr_reg;
	reg         op_ok;
	reg  [31:0] rd_mux;

	wire        cyc_done;
	wire [15:0] cyc_rdata;
	wire [35:0] sw;
	wire        cyc_wr;
	wire        same_er;
	wire [2:0]  new_op;
	wire        busy;
	wire        wr_cmd;
	wire        wr_other;

	assign busy     = (state_reg != S_IDLE);
	assign new_op   = hwdata[2:0];
	assign wr_cmd   = ap_wr_reg && (ap_addr_reg == `FNC_REG_CMD);
	assign wr_other = ap_wr_reg && (ap_addr_reg == `FNC_REG_ADDR ||
		ap_addr_reg == `FNC_REG_WDATA || ap_addr_reg == `FNC_REG_CFG);
	assign sw       = polling_reg ? {addr_reg, wdata_reg} :
		step_word(op_reg, step_reg, addr_reg, wdata_reg);
	assign cyc_wr   = !polling_reg && op_reg != `FNC_OP_READ &&
		op_reg != `FNC_OP_POLL;
	assign same_er  = er_blk_reg ?
		(addr_reg[19:`FNC_BLOCK_LSB] == er_addr_reg[19:`FNC_BLOCK_LSB]) :
		(addr_reg[19:`FNC_SECT_LSB] == er_addr_reg[19:`FNC_SECT_LSB]);
	// protect level guards the boot area
	// protect level only changes while nothing runs
	assign flash_wp_n = wp_cfg_reg;
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;

	// ==========================================================
	// Which operations may start now
	always @*
	begin
		case (new_op)
		`FNC_OP_READ:   op_ok = 1'b1;
		// no program while an erase would be running
		// program outside the suspended area only
		`FNC_OP_PROG:   op_ok = !erase_act_reg || (susp_reg && !same_er);
		// no new erase while one is pending
		`FNC_OP_SECT:   op_ok = !erase_act_reg;
		`FNC_OP_BLOCK:  op_ok = !erase_act_reg;
		// suspend and resume only around an erase
		`FNC_OP_SUSP:   op_ok = erase_act_reg && !susp_reg;
		`FNC_OP_RESUME: op_ok = susp_reg;
		`FNC_OP_POLL:   op_ok = erase_act_reg && !susp_reg;
		default:        op_ok = 1'b0;
		endcase
	end

	// ==========================================================
	// Register read mux
	always @*
	begin
		rd_mux = 32'h00000000;
		case (haddr[7:0])
		`FNC_REG_CMD:    rd_mux[2:0]  = op_reg;
		`FNC_REG_ADDR:   rd_mux[19:0] = addr_reg;
		`FNC_REG_WDATA:  rd_mux[15:0] = wdata_reg;
		`FNC_REG_RDATA:  rd_mux[15:0] = rdata_reg;
		`FNC_REG_STATUS:
		begin
			rd_mux[`FNC_ST_BUSY]    = busy;
			rd_mux[`FNC_ST_DONE]    = done_reg;
			rd_mux[`FNC_ST_ERR]     = err_reg;
			rd_mux[`FNC_ST_REFUSED] = refused_reg;
			rd_mux[`FNC_ST_ERASE]   = erase_act_reg;
			rd_mux[`FNC_ST_SUSP]    = susp_reg;
			// pin low while the flash is busy
			rd_mux[`FNC_ST_RDY]     = flash_ready_busy_n;
		end
		`FNC_REG_CFG:    rd_mux[`FNC_CFG_WP] = wp_cfg_reg;
		default:         rd_mux = 32'h00000000;
		endcase
	end

	// ==========================================================
	// AHB address phase capture
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ap_wr_reg   <= 1'b0;
			ap_addr_reg <= 8'h00;
			hrdata      <= 32'h00000000;
		end
		else if (hready)
		begin
			ap_wr_reg   <= hsel && htrans[1] && hwrite;
			ap_addr_reg <= haddr[7:0];
			if (hsel && htrans[1] && !hwrite)
				hrdata <= rd_mux;
		end
	end

	// ==========================================================
	// Command sequencer and software registers
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg     <= S_IDLE;
			op_reg        <= 3'h0;
			step_reg      <= 3'h0;
			addr_reg      <= 20'h00000;
			wdata_reg     <= 16'h0000;
			rdata_reg     <= 16'h0000;
			prev_reg      <= 16'h0000;
			tmo_reg       <= 13'h0000;
			polling_reg   <= 1'b0;
			first_reg     <= 1'b0;
			done_reg      <= 1'b0;
			err_reg       <= 1'b0;
			refused_reg   <= 1'b0;
			erase_act_reg <= 1'b0;
			susp_reg      <= 1'b0;
			er_blk_reg    <= 1'b0;
			er_addr_reg   <= 20'h00000;
			wp_cfg_reg    <= `FNC_CFG_RESET;
			cyc_start_reg <= 1'b0;
		end
		else
		begin
			cyc_start_reg <= 1'b0;
			if (tmo_reg != 13'h1fff)
				tmo_reg <= tmo_reg + 13'h0001;
			// Settings change only when idle; no half-built sequence
			// command while busy is refused
			if (wr_cmd && busy)
				refused_reg <= 1'b1;
			// Suspended erase must let reads and programs elsewhere
			if (wr_other && (busy || (erase_act_reg && !susp_reg)))
				refused_reg <= 1'b1;
			else if (wr_other)
				case (ap_addr_reg)
				`FNC_REG_ADDR:  addr_reg   <= hwdata[19:0];
				`FNC_REG_WDATA: wdata_reg  <= hwdata[15:0];
				default:        wp_cfg_reg <= hwdata[`FNC_CFG_WP];
				endcase
			case (state_reg)
			S_IDLE:
				if (wr_cmd && op_ok)
				begin
					op_reg      <= new_op;
					step_reg    <= 3'h0;
					done_reg    <= 1'b0;
					err_reg     <= 1'b0;
					refused_reg <= 1'b0;
					state_reg   <= S_ISSUE;
				end
				else if (wr_cmd)
					refused_reg <= 1'b1;
			S_ISSUE:
			begin
				cyc_start_reg <= 1'b1;
				state_reg     <= S_WAIT;
			end
			S_WAIT:
				if (cyc_done && polling_reg)
				begin
					prev_reg  <= cyc_rdata;
					first_reg <= 1'b0;
					if (!first_reg && prev_reg[`FNC_TOGGLE_BIT] ==
						cyc_rdata[`FNC_TOGGLE_BIT])
					begin
						polling_reg <= 1'b0;
						rdata_reg   <= cyc_rdata;
						done_reg    <= 1'b1;
						if (op_reg == `FNC_OP_POLL)
							erase_act_reg <= 1'b0;
						state_reg   <= S_IDLE;
					end
					else if (op_reg == `FNC_OP_PROG &&
						tmo_reg >= PROG_CYC)
					begin
						polling_reg <= 1'b0;
						err_reg     <= 1'b1;
						state_reg   <= S_IDLE;
					end
					else
						state_reg <= S_ISSUE;
				end
				else if (cyc_done && step_reg == last_step(op_reg))
					case (op_reg)
					// program and poll end in toggle polling; the final read lands in rdata_reg unless a program times out
					`FNC_OP_PROG, `FNC_OP_POLL:
					begin
						polling_reg <= 1'b1;
						first_reg   <= 1'b1;
						tmo_reg     <= 13'h0000;
						state_reg   <= S_ISSUE;
					end
					// erase runs on after the sixth pulse
					`FNC_OP_SECT, `FNC_OP_BLOCK:
					begin
						erase_act_reg <= 1'b1;
						susp_reg      <= 1'b0;
						er_addr_reg   <= addr_reg;
						er_blk_reg    <= (op_reg == `FNC_OP_BLOCK);
						done_reg      <= 1'b1;
						state_reg     <= S_IDLE;
					end
					// give the flash time to reach read mode
					`FNC_OP_SUSP:
					begin
						tmo_reg   <= 13'h0000;
						state_reg <= S_SUSP;
					end
					`FNC_OP_RESUME:
					begin
						susp_reg  <= 1'b0;
						done_reg  <= 1'b1;
						state_reg <= S_IDLE;
					end
					default:
					begin
						rdata_reg <= cyc_rdata;
						done_reg  <= 1'b1;
						state_reg <= S_IDLE;
					end
					endcase
				else if (cyc_done)
				begin
					step_reg  <= step_reg + 3'h1;
					state_reg <= S_ISSUE;
				end
			S_SUSP:
				if (tmo_reg >= SUSP_CYC - 13'h0001)
				begin
					susp_reg  <= 1'b1;
					done_reg  <= 1'b1;
					state_reg <= S_IDLE;
				end
			default:
				state_reg <= S_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Pin cycle engine
	fnc_bus_cycle u_cycle
	(
		.hclk         (hclk),
		.hresetn      (hresetn),
		.start        (cyc_start_reg),
		.wr           (cyc_wr),
		.addr         (sw[35:16]),
		.wdata        (sw[15:0]),
		.done         (cyc_done),
		.rdata        (cyc_rdata),
		.flash_addr   (flash_addr),
		.flash_ce_n   (flash_ce_n),
		.flash_we_n   (flash_we_n),
		.flash_oe_n   (flash_oe_n),
		.flash_dq_out (flash_dq_out),
		.flash_dq_oe  (flash_dq_oe),
		.flash_dq_in  (flash_dq_in)
	);

endmodule

// File: testbench/fnc_flash_model.sv
// Purpose: behavioural parallel NOR flash for the controller bench
// Assumes: controller drives the pins; erased array reads all ones
// Notes:   times scaled down; suspend is taken at once
`timescale 1ns/100ps
module fnc_flash_model
#(
	parameter [19:0] BOOT_HI = 20'h01fff,
	parameter        PROG_NS = 2000,
	parameter        ERAS_NS = 4000
)
(
	// Flash pins
	input  wire [19:0] flash_addr,
	input  wire        flash_ce_n,
	input  wire        flash_we_n,
	input  wire        flash_oe_n,
	input  wire [15:0] flash_dq_out,
	input  wire        flash_dq_oe,
	input  wire        flash_wp_n,
	output wire [15:0] flash_dq_in,
	output wire        rb_pull_low,
	// Bench controls
	input  wire [7:0]  acc_ns,
	input  wire        stuck
);
	// ==========================================================
	// State
	logic [15:0] mem [0:1048575];
	logic [19:0] lat_a, er_a;
	logic [15:0] rd = 16'h0000, pd = 16'h0000;
	logic [2:0]  st = 3'h0;
	logic        open_w = 1'b0, vld = 1'b0, tg = 1'b0, t2 = 1'b0;
	logic        susp = 1'b0, blk = 1'b0;
	int          left = 0, eleft = 0;
	initial
		for (int k = 0; k < 1048576; k++)
			mem[k] = 16'hffff;
	function logic in_er(input logic [19:0] a);
		in_er = blk ? a[19:15] == er_a[19:15] : a[19:11] == er_a[19:11];
	endfunction
	always #4
	begin
		if (left > 0 && !stuck)
			left = left - 4;
		if (eleft > 0 && !susp)
			eleft = eleft - 4;
	end
	assign rb_pull_low = left > 0 || (eleft > 0 && !susp);
	assign flash_dq_in = (!flash_ce_n && !flash_oe_n && vld) ? rd : ~rd;
	task wr_cmd(input logic [19:0] a, input logic [15:0] d);
		logic [19:0] b;
		logic        u1, u2;
		u1 = a[10:0] == 11'h555;
		u2 = a[10:0] == 11'h2aa;
		b = d[7:0] == 8'h30 ? {a[19:15], 15'h0} : {a[19:11], 11'h0};
		if (left > 0)
			st = 3'h0;
		else if (eleft > 0 && !susp)
			susp = d[7:0] == 8'hb0;
		else if (susp && st == 3'h0 && d[7:0] == 8'h30)
			susp = 1'b0;
		else if (st == 3'h3)
		begin
			st = 3'h0;
			if (!(susp && in_er(a)))
			begin
				mem[a] = mem[a] & d;
				pd = d;
				left = PROG_NS;
			end
		end
		else if (st == 3'h6)
		begin
			st = 3'h0;
			if ((d[7:0] == 8'h50 || d[7:0] == 8'h30)
				&& (flash_wp_n || a > BOOT_HI))
			begin
				blk = d[7:0] == 8'h30;
				er_a = a;
				for (int k = 0; k < (blk ? 32768 : 2048); k++)
					mem[b + k[19:0]] = 16'hffff;
				eleft = ERAS_NS;
			end
		end
		else if (u1 && d[7:0] == 8'haa && (st == 3'h0 || st == 3'h4))
			st = st + 3'h1;
		else if (u2 && d[7:0] == 8'h55 && (st == 3'h1 || st == 3'h5))
			st = st + 3'h1;
		else if (u1 && st == 3'h2 && d[7:0] == 8'ha0)
			st = 3'h3;
		else if (u1 && st == 3'h2 && d[7:0] == 8'h80 && !susp)
			st = 3'h4;
		else
			st = 3'h0;
	endtask
	always @(negedge flash_we_n or negedge flash_ce_n)
		if (!flash_we_n && !flash_ce_n && flash_oe_n)
		begin
			lat_a = flash_addr;
			open_w = 1'b1;
		end
	always @(posedge flash_we_n or posedge flash_ce_n)
		if (open_w)
		begin
			open_w = 1'b0;
			wr_cmd(lat_a, flash_dq_oe ? flash_dq_out : ~flash_dq_out);
		end
	always @(negedge flash_oe_n)
		if (!flash_ce_n)
		begin
			vld = 1'b0;
			if (rb_pull_low)
			begin
				tg = ~tg;
				t2 = ~t2;
				rd = {8'h00, left > 0 ? ~pd[7] : 1'b0, tg, 3'h0, t2, 2'h0};
			end
			else if (susp && in_er(flash_addr))
			begin
				t2 = ~t2;
				rd = {8'h00, 2'h3, 3'h0, t2, 2'h0};
			end
			else
				rd = mem[flash_addr];
			#(acc_ns) vld = 1'b1;
		end
endmodule

// File: testbench/fnc_flash_ctrl_checker.sv
// Purpose: pin protocol checks for the flash command controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   pulse widths follow the controller's fixed timing
`timescale 1ns/100ps
module fnc_flash_ctrl_checker
(
	// Clock and reset
	input wire        hclk,
	input wire        hresetn,
	// Flash pins
	input wire [19:0] flash_addr,
	input wire        flash_ce_n,
	input wire        flash_we_n,
	input wire        flash_oe_n,
	input wire [15:0] flash_dq_out,
	input wire        flash_dq_oe,
	input wire        flash_wp_n
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	chk_strobe_select: assert property (
		!flash_we_n |-> !flash_ce_n && flash_oe_n)
		else $error("write strobe without select");
	chk_addr_held: assert property (
		!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out))
		else $error("address moved under strobe");
	chk_data_rise: assert property (
		$rose(flash_we_n) |-> flash_dq_oe && !flash_ce_n)
		else $error("data released before strobe rise");
	chk_we_width: assert property (
		$fell(flash_we_n) |-> ##9 !flash_we_n ##1 flash_we_n)
		else $error("strobe width wrong");
	chk_read_pulse: assert property (
		$fell(flash_oe_n) |-> (!flash_ce_n && !flash_dq_oe)
		##17 !flash_oe_n ##1 flash_oe_n)
		else $error("read pulse wrong");
	chk_no_fight: assert property (
		!flash_oe_n |-> !flash_dq_oe && flash_we_n)
		else $error("bus driven during read");
	chk_dq_drop: assert property (
		$rose(flash_ce_n) |=> !flash_dq_oe)
		else $error("data bus held after cycle");
	chk_wp_steady: assert property (
		!flash_ce_n |-> $stable(flash_wp_n))
		else $error("protect level moved in cycle");
	chk_select_gap: assert property (
		$rose(flash_ce_n) |-> flash_ce_n [*3])
		else $error("select gap too short");
endmodule

// File: testbench/tb.sv
// Purpose: self-checking bench for the flash command controller
// Assumes: zero-wait AHB-Lite slave, behavioural flash on the pins
// Notes:   random targets stay clear of the erase targets
`timescale 1ns/100ps
`include "fnc_consts.vh"
module tb;
	logic        hclk, hresetn, hsel, hwrite, stuck;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, r, r2;
	logic [19:0] a;
	logic [15:0] d;
	logic [7:0]  acc;
	int          err_total, compares, i, n;
	wire         hreadyout, hresp, flash_ce_n, flash_we_n, flash_oe_n;
	wire         flash_dq_oe, flash_wp_n, rb_pull_low;
	wire  [31:0] hrdata;
	wire  [19:0] flash_addr;
	wire  [15:0] flash_dq_out, flash_dq_in;
	// Open-drain busy line with its pull-up
	wire         flash_ready_busy_n = rb_pull_low ? 1'b0 : 1'b1;
	fnc_flash_ctrl dut_u
	(
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.flash_addr, .flash_ce_n, .flash_we_n, .flash_oe_n,
		.flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_wp_n,
		.flash_ready_busy_n
	);
	fnc_flash_model fm_u
	(
		.flash_addr, .flash_ce_n, .flash_we_n, .flash_oe_n,
		.flash_dq_out, .flash_dq_oe, .flash_wp_n, .flash_dq_in,
		.rb_pull_low, .acc_ns(acc), .stuck
	);
	// ==========================================================
	// Tasks
	task chk(input logic [31:0] got, input logic [31:0] want);
		compares++;
		if (got !== want)
		begin
			err_total++;
			$display("wrong value t=%0t got %h exp %h", $time, got, want);
		end
	endtask
	task summarize;
		if (err_total == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, ad};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		r = hrdata;
	endtask
	// Polling is bounded; a stall shows up as a wrong status
	task run(input logic [2:0] op, input logic [19:0] ta,
		input logic [15:0] td);
		bus(1'b1, `FNC_REG_ADDR, {12'h0, ta});
		bus(1'b1, `FNC_REG_WDATA, {16'h0, td});
		bus(1'b1, `FNC_REG_CMD, {29'h0, op});
		n = 0;
		bus(1'b0, `FNC_REG_STATUS, 32'h0);
		while (r[`FNC_ST_BUSY] !== 1'b0 && n < 3000)
		begin
			bus(1'b0, `FNC_REG_STATUS, 32'h0);
			n++;
		end
	endtask
	task fetch(input logic [19:0] ta);
		run(`FNC_OP_READ, ta, 16'h0);
		bus(1'b0, `FNC_REG_RDATA, 32'h0);
	endtask
	// ==========================================================
	// Stimulus
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	initial
	begin
		#200000;
		err_total++;
		summarize();
	end
	initial
	begin
		{hresetn, hsel, hwrite, stuck, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		acc = 8'h05;
		err_total = 0;
		compares = 0;
		void'($urandom(90));
		repeat (10) @(posedge hclk);
		chk({25'h0, hreadyout, hresp, flash_ce_n, flash_we_n,
			flash_oe_n, flash_dq_oe, flash_wp_n}, 32'h5d);
		hresetn <= 1'b1;
		bus(1'b0, `FNC_REG_CFG, 32'h0);
		chk(r, 32'h1);
		bus(1'b0, `FNC_REG_STATUS, 32'h0);
		chk(r & 32'h7f, 32'h40);
		bus(1'b1, 8'h20, 32'hffffffff);
		bus(1'b0, 8'h20, 32'h0);
		chk(r, 32'h0);
		for (i = 0; i < 6; i++)
		begin
			a = 20'h10000 | 20'($urandom);
			d = i == 0 ? 16'h0000 : i == 1 ? 16'hffff : 16'($urandom);
			acc <= i[0] ? 8'd60 : 8'd5;
			run(`FNC_OP_PROG, a, d);
			chk(r & 32'h7f, 32'h42);
			bus(1'b0, `FNC_REG_RDATA, 32'h0);
			chk(r, {16'h0, d});
			fetch(a);
			chk(r, {16'h0, d});
		end
		bus(1'b1, `FNC_REG_WDATA, {16'h0, d});
		bus(1'b1, `FNC_REG_CMD, 32'h2);
		bus(1'b1, `FNC_REG_CMD, 32'h1);
		bus(1'b0, `FNC_REG_STATUS, 32'h0);
		chk(r & 32'h9, 32'h9);
		while (r[`FNC_ST_BUSY] !== 1'b0)
			bus(1'b0, `FNC_REG_STATUS, 32'h0);
		chk(r & 32'h7f, 32'h4a);
		run(`FNC_OP_PROG, 20'h04100, 16'h0000);
		run(`FNC_OP_PROG, 20'h06000, 16'h0000);
		run(`FNC_OP_SECT, 20'h04100, 16'h0);
		chk(r & 32'h7f, 32'h12);
		run(`FNC_OP_PROG, 20'h09000, 16'h5a5a);
		chk(r & 32'h7f, 32'h1a);
		run(`FNC_OP_SUSP, 20'h04100, 16'h0);
		chk(r & 32'h7f, 32'h72);
		fetch(20'h04100);
		r2 = r;
		fetch(20'h04100);
		chk({30'h0, r[6], r[2] ^ r2[2]}, 32'h3);
		fetch(a);
		chk(r, {16'h0, d});
		run(`FNC_OP_PROG, 20'h04101, 16'h1111);
		chk(r & 32'h7f, 32'h7a);
		run(`FNC_OP_PROG, 20'h09000, 16'h5a5a);
		chk(r & 32'h7f, 32'h72);
		run(`FNC_OP_RESUME, 20'h00000, 16'h0);
		chk(r & 32'h7f, 32'h12);
		run(`FNC_OP_POLL, 20'h04100, 16'h0);
		chk(r & 32'h7f, 32'h42);
		fetch(20'h04100);
		chk(r, 32'hffff);
		run(`FNC_OP_BLOCK, 20'h06000, 16'h0);
		run(`FNC_OP_POLL, 20'h06000, 16'h0);
		fetch(20'h06000);
		chk(r, 32'hffff);
		fetch(20'h09000);
		chk(r, 32'h5a5a);
		foreach (d[i])
			if (i < 4)
			begin
				run(i == 0 ? 3'h0 : 3'(i + 4), 20'h0, 16'h0);
				chk(r & 32'h8, 32'h8);
			end
		run(`FNC_OP_PROG, 20'h00100, 16'h0f0f);
		// protect level changed only between operations
		bus(1'b1, `FNC_REG_CFG, 32'h0);
		@(negedge hclk);
		chk({31'h0, flash_wp_n}, 32'h0);
		run(`FNC_OP_SECT, 20'h00100, 16'h0);
		chk(r & 32'h7f, 32'h52);
		run(`FNC_OP_POLL, 20'h00100, 16'h0);
		fetch(20'h00100);
		chk(r, 32'h0f0f);
		bus(1'b1, `FNC_REG_CFG, 32'h1);
		stuck <= 1'b1;
		run(`FNC_OP_PROG, 20'h0a000, 16'h00ff);
		chk(r & 32'h4, 32'h4);
		stuck <= 1'b0;
		repeat (2500) @(posedge hclk);
		fetch(20'h0a000);
		chk(r, 32'h00ff);
		summarize();
	end
endmodule
bind fnc_flash_ctrl fnc_flash_ctrl_checker chk_u
(
	.hclk, .hresetn, .flash_addr, .flash_ce_n, .flash_we_n,
	.flash_oe_n, .flash_dq_out, .flash_dq_oe, .flash_wp_n
);
